// ==== hdl/afei_fifo_event_irq.sv ====
// Result queue event interrupt block with an Avalon-MM register slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module afei_fifo_event_irq
	import afei_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Result queue level flags, one group per channel
	input wire afei_queue_flags_t ch0_result_queue,
	input wire afei_queue_flags_t ch1_result_queue,
	input wire afei_queue_flags_t ch2_result_queue,
	// Avalon-MM slave
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	// Processor interrupt lines 117..109, bit n is line 109+n
	output logic [EVENT_COUNT-1:0] proc_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic afei_sel_t afei_decode(input logic [31:0] addr);
		case (addr)
			ENABLE_ADDR: afei_decode = AFEI_SEL_ENABLE;
			STATUS_ADDR: afei_decode = AFEI_SEL_STATUS;
			CLEAR_ADDR: afei_decode = AFEI_SEL_CLEAR;
			default: afei_decode = AFEI_SEL_NONE;
		endcase
	endfunction : afei_decode

	////////////////////////////////////////////////////////////////////////////
	// Edge detection

	afei_queue_flags_t chan_now [CHAN_COUNT];
	afei_queue_flags_t chan_prev_ff [CHAN_COUNT];
	logic [EVENT_COUNT-1:0] event_set;

	assign chan_now[0] = ch0_result_queue;
	assign chan_now[1] = ch1_result_queue;
	assign chan_now[2] = ch2_result_queue;

	// Previous samples start at reset levels: empty high, fill flags low
	genvar gc;
	generate
		for (gc = 0; gc < CHAN_COUNT; gc++) begin : g_chan
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					chan_prev_ff[gc] <= '{empty: 1'b1, almost_full: 1'b0, full: 1'b0};
				end else begin
					chan_prev_ff[gc] <= chan_now[gc];
				end
			end
			assign event_set[gc*EVENTS_PER_CHAN+NONEMPTY_POS] =
				chan_prev_ff[gc].empty & ~chan_now[gc].empty;
			assign event_set[gc*EVENTS_PER_CHAN+AFULL_POS] =
				~chan_prev_ff[gc].almost_full & chan_now[gc].almost_full;
			assign event_set[gc*EVENTS_PER_CHAN+FULL_POS] =
				~chan_prev_ff[gc].full & chan_now[gc].full;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Register slave

	afei_bus_state_t bus_state_ff;
	afei_bus_state_t nxt_bus_state;
	afei_sel_t access_sel;
	logic access_req;
	logic access_take;
	logic wr_enable;
	logic wr_clear;
	logic [EVENT_COUNT-1:0] enable_ff;
	logic [EVENT_COUNT-1:0] nxt_enable;
	logic [EVENT_COUNT-1:0] status_ff;
	logic [EVENT_COUNT-1:0] nxt_status;
	logic [EVENT_COUNT-1:0] clear_bits;
	logic [31:0] nxt_readdata;
	logic [1:0] nxt_response;

	assign access_sel = afei_decode(avs_address);
	assign access_req = avs_read | avs_write;
	// Request is taken on the edge where waitrequest is seen low
	assign access_take = access_req & (bus_state_ff == AFEI_DONE);
	assign nxt_bus_state = (access_req && bus_state_ff == AFEI_IDLE) ? AFEI_DONE : AFEI_IDLE;
	assign wr_enable = access_take & avs_write & (access_sel == AFEI_SEL_ENABLE) &
		avs_byteenable[0] & avs_byteenable[1];
	assign wr_clear = access_take & avs_write & (access_sel == AFEI_SEL_CLEAR) &
		avs_byteenable[0] & avs_byteenable[1];
	// Bits 31..9 of writes are dropped
	assign nxt_enable = wr_enable ? avs_writedata[EVENT_COUNT-1:0] : enable_ff;
	// Clear is a strobe only; nothing is stored
	assign clear_bits = wr_clear ? avs_writedata[EVENT_COUNT-1:0] : '0;
	// Set wins over clear; bits hold otherwise
	assign nxt_status = (status_ff & ~clear_bits) | event_set;

	// Read mux; clear register reads as zero
	assign nxt_readdata = !(access_req && avs_read && bus_state_ff == AFEI_IDLE) ? READ_IDLE :
		(access_sel == AFEI_SEL_ENABLE) ? {23'h000000, enable_ff} :
		(access_sel == AFEI_SEL_STATUS) ? {23'h000000, status_ff} :
		UNMAPPED_DATA;
	assign nxt_response = (access_sel == AFEI_SEL_NONE ||
		(avs_write && access_sel == AFEI_SEL_STATUS)) ? 2'h2 : 2'h0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bus_state_ff <= AFEI_IDLE;
			avs_readdata <= READ_IDLE;
			avs_response <= 2'h0;
		end else begin
			bus_state_ff <= nxt_bus_state;
			avs_readdata <= nxt_readdata;
			avs_response <= nxt_response;
		end
	end

	// Waitrequest is high at rest and drops for one cycle to answer
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(access_req & (bus_state_ff == AFEI_IDLE));
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			enable_ff <= ENABLE_RESET;
			status_ff <= STATUS_RESET;
		end else begin
			enable_ff <= nxt_enable;
			status_ff <= nxt_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt lines, registered from the next status and enable

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			proc_irq <= '0;
		end else begin
			proc_irq <= nxt_status & nxt_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_clear_write;
		wr_clear;
	endsequence

	sequence s_bit4_gone;
		##1 !status_ff[4];
	endsequence

	property p_line_matches;
		@(posedge clock) disable iff (sys_rst)
		1'b1 |=> proc_irq == ($past(nxt_status) & $past(nxt_enable));
	endproperty

	a_irq_and_gate: assert property (p_line_matches)
		else $error("interrupt line not status and enable");

	a_irq_mask_off: assert property (@(posedge clock) disable iff (sys_rst)
		(enable_ff == '0 && !wr_enable) |=> proc_irq == '0)
		else $error("masked status raised an interrupt");

	a_ch2_nonempty: assert property (@(posedge clock) disable iff (sys_rst)
		($fell(ch2_result_queue.empty)) |=> status_ff[8])
		else $error("channel 2 nonempty event lost");

	a_ch1_afull: assert property (@(posedge clock) disable iff (sys_rst)
		($rose(ch1_result_queue.almost_full)) |=> status_ff[4])
		else $error("channel 1 almost-full event lost");

	a_ch0_full: assert property (@(posedge clock) disable iff (sys_rst)
		($rose(ch0_result_queue.full)) |=> status_ff[0])
		else $error("channel 0 full event lost");

	a_set_beats_clear: assert property (@(posedge clock) disable iff (sys_rst)
		s_clear_write |=> (status_ff & $past(event_set)) == $past(event_set))
		else $error("clear won over a set event");

	a_clear_one: assert property (@(posedge clock) disable iff (sys_rst)
		(s_clear_write ##0 (avs_writedata[4] && !event_set[4])) |-> s_bit4_gone)
		else $error("status bit 4 not cleared");

	a_clear_zero: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_clear && !avs_writedata[1] && status_ff[1]) |=> status_ff[1])
		else $error("writing zero cleared a status bit");

	a_status_sticky: assert property (@(posedge clock) disable iff (sys_rst)
		(status_ff[7] && !wr_clear) |=> status_ff[7])
		else $error("status bit dropped without clear");

	a_upper_zero: assert property (@(posedge clock) disable iff (sys_rst)
		!avs_waitrequest |-> avs_readdata[31:EVENT_COUNT] == '0)
		else $error("reserved read bits not zero");

	a_answer_bound: assert property (@(posedge clock) disable iff (sys_rst)
		($rose(avs_read) || $rose(avs_write)) |-> ##[1:2] !avs_waitrequest)
		else $error("bus answer late");

	a_clear_reads_zero: assert property (@(posedge clock) disable iff (sys_rst)
		(avs_read && access_sel == AFEI_SEL_CLEAR && bus_state_ff == AFEI_IDLE)
		|=> avs_readdata == '0)
		else $error("clear register read nonzero");

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake and register checks

	// A request meets an idle slave
	sequence s_req_seen;
		access_req && bus_state_ff == AFEI_IDLE;
	endsequence

	// Slave answers on the next edge
	sequence s_answer;
		##1 !avs_waitrequest;
	endsequence

	// Slave returns to rest one edge later
	sequence s_answer_done;
		##1 avs_waitrequest;
	endsequence

	property p_wait_one_cycle;
		@(posedge clock) disable iff (sys_rst)
		s_req_seen |-> s_answer ##0 s_answer_done;
	endproperty

	a_wait_one_cycle: assert property (p_wait_one_cycle)
		else $error("waitrequest not low for exactly one cycle");

	property p_wait_rest;
		@(posedge clock) disable iff (sys_rst)
		(!access_req && bus_state_ff == AFEI_IDLE) |=> avs_waitrequest;
	endproperty

	a_wait_at_rest: assert property (p_wait_rest)
		else $error("waitrequest low with no request");

	property p_read_status;
		@(posedge clock) disable iff (sys_rst)
		(s_req_seen ##0 (avs_read && access_sel == AFEI_SEL_STATUS))
		|=> avs_readdata == {23'h000000, $past(status_ff)};
	endproperty

	a_read_status: assert property (p_read_status)
		else $error("status read data wrong");

	property p_read_enable;
		@(posedge clock) disable iff (sys_rst)
		(s_req_seen ##0 (avs_read && access_sel == AFEI_SEL_ENABLE))
		|=> avs_readdata == {23'h000000, $past(enable_ff)};
	endproperty

	a_read_enable: assert property (p_read_enable)
		else $error("enable read data wrong");

	property p_readdata_idle;
		@(posedge clock) disable iff (sys_rst)
		(bus_state_ff == AFEI_DONE) |=> avs_readdata == READ_IDLE;
	endproperty

	a_readdata_idle: assert property (p_readdata_idle)
		else $error("read data stood longer than one cycle");

	property p_resp_unmapped;
		@(posedge clock) disable iff (sys_rst)
		(s_req_seen ##0 (access_sel == AFEI_SEL_NONE)) |=> avs_response == 2'h2;
	endproperty

	a_resp_unmapped: assert property (p_resp_unmapped)
		else $error("unmapped access not refused");

	property p_resp_okay;
		@(posedge clock) disable iff (sys_rst)
		(s_req_seen ##0 (avs_read && access_sel != AFEI_SEL_NONE)) |=> avs_response == 2'h0;
	endproperty

	a_resp_okay: assert property (p_resp_okay)
		else $error("mapped read not answered okay");

	property p_status_write_ignored;
		@(posedge clock) disable iff (sys_rst)
		(access_take && avs_write && access_sel == AFEI_SEL_STATUS && event_set == '0)
		|=> $stable(status_ff);
	endproperty

	a_status_read_only: assert property (p_status_write_ignored)
		else $error("write changed the status register");

	property p_enable_lands;
		@(posedge clock) disable iff (sys_rst)
		wr_enable |=> enable_ff == $past(avs_writedata[EVENT_COUNT-1:0]);
	endproperty

	a_enable_lands: assert property (p_enable_lands)
		else $error("enable write did not land");

	property p_enable_hold;
		@(posedge clock) disable iff (sys_rst)
		!wr_enable |=> $stable(enable_ff);
	endproperty

	a_enable_hold: assert property (p_enable_hold)
		else $error("enable changed without a write");

	// No disable here: the reset itself is what is checked
	property p_reset_state;
		@(posedge clock)
		sys_rst |=> (status_ff == STATUS_RESET && enable_ff == ENABLE_RESET &&
			proc_irq == '0 && avs_waitrequest && avs_readdata == READ_IDLE);
	endproperty

	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");

	////////////////////////////////////////////////////////////////////////////
	// Per-bit status checks

	genvar gb;
	generate
		for (gb = 0; gb < EVENT_COUNT; gb++) begin : g_bit_chk
			a_bit_sets: assert property (@(posedge clock) disable iff (sys_rst)
				event_set[gb] |=> status_ff[gb])
				else $error("event did not set its status bit");

			a_bit_clears: assert property (@(posedge clock) disable iff (sys_rst)
				(clear_bits[gb] && !event_set[gb]) |=> !status_ff[gb])
				else $error("clear did not reset its status bit");

			a_bit_no_set: assert property (@(posedge clock) disable iff (sys_rst)
				(!status_ff[gb] && !event_set[gb]) |=> !status_ff[gb])
				else $error("status bit set without an event");

			a_line_follows: assert property (@(posedge clock) disable iff (sys_rst)
				(status_ff[gb] && enable_ff[gb] && !clear_bits[gb] && !wr_enable)
				|=> proc_irq[gb])
				else $error("enabled status bit gave no interrupt");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Per-channel event checks

	genvar gk;
	generate
		for (gk = 0; gk < CHAN_COUNT; gk++) begin : g_chan_chk
			a_chan_nonempty: assert property (@(posedge clock) disable iff (sys_rst)
				$fell(chan_now[gk].empty) |=> status_ff[gk*EVENTS_PER_CHAN+NONEMPTY_POS])
				else $error("nonempty event lost");

			a_chan_afull: assert property (@(posedge clock) disable iff (sys_rst)
				$rose(chan_now[gk].almost_full) |=> status_ff[gk*EVENTS_PER_CHAN+AFULL_POS])
				else $error("almost-full event lost");

			a_chan_full: assert property (@(posedge clock) disable iff (sys_rst)
				$rose(chan_now[gk].full) |=> status_ff[gk*EVENTS_PER_CHAN+FULL_POS])
				else $error("full event lost");
		end
	endgenerate

endmodule : afei_fifo_event_irq

// ==== hdl/afei_pkg.sv ====
// Package for the result queue event interrupt block: addresses, layouts, reset values
package afei_pkg;

	// Register byte addresses (full system addresses)
	localparam logic [31:0] ENABLE_ADDR = 32'h4002_1218;
	localparam logic [31:0] STATUS_ADDR = 32'h4002_121c;
	localparam logic [31:0] CLEAR_ADDR = 32'h4002_1220;

	// Field layout
	localparam int EVENT_COUNT = 9;
	localparam int CHAN_COUNT = 3;
	localparam int EVENTS_PER_CHAN = 3;
	localparam int FULL_POS = 0;
	localparam int AFULL_POS = 1;
	localparam int NONEMPTY_POS = 2;
	// Processor interrupt line that status bit 0 feeds
	localparam int FIRST_IRQ_LINE = 109;

	// Reset values
	localparam logic [8:0] ENABLE_RESET = 9'h000;
	localparam logic [8:0] STATUS_RESET = 9'h000;
	localparam logic [31:0] READ_IDLE = 32'h0000_0000;
	// Unmapped reads return this value
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// Level flags of one result queue
	typedef struct packed {
		logic empty;
		logic almost_full;
		logic full;
	} afei_queue_flags_t;

	// Register access decode
	typedef enum logic [1:0] {
		AFEI_SEL_NONE,
		AFEI_SEL_ENABLE,
		AFEI_SEL_STATUS,
		AFEI_SEL_CLEAR
	} afei_sel_t;

	// Slave answer state
	typedef enum logic {
		AFEI_IDLE,
		AFEI_DONE
	} afei_bus_state_t;

endpackage : afei_pkg

// ==== test/afei_queue_model.sv ====
// Result queue stand-in: counts stored words and drives the level flags
`timescale 1ns/1ps
module afei_queue_model
	import afei_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Word strobes
	input wire logic push,
	input wire logic pop,
	// Level flags
	output afei_queue_flags_t flags
);
	logic [2:0] count_ff;
	always_ff @(posedge clock) begin
		if (sys_rst) count_ff <= 3'h0;
		else if (push && count_ff != 3'h4) count_ff <= count_ff + 3'h1;
		else if (pop && count_ff != 3'h0) count_ff <= count_ff - 3'h1;
	end
	assign flags.empty = (count_ff == 3'h0);
	assign flags.almost_full = (count_ff >= 3'h3);
	assign flags.full = (count_ff == 3'h4);
endmodule : afei_queue_model

// ==== test/tb_afei_fifo_event_irq.sv ====
// Self-checking bench for the result queue event interrupt block
`timescale 1ns/1ps
module tb_afei_fifo_event_irq import afei_pkg::*; ;
	logic clock, sys_rst, rd, wr;
	logic [31:0] addr, wdata, rv;
	logic [2:0] push, pop;
	logic [1:0] rr;
	logic [8:0] st, en;
	wire logic [31:0] rdata;
	wire logic wreq;
	wire logic [1:0] resp;
	wire logic [8:0] irq;
	afei_queue_flags_t qf [3];
	int errors, compares, cycles;
	////////////////////////////////////////////////////////////
	for (genvar i = 0; i < 3; i++) begin : g_q
		afei_queue_model afei_queue_model_inst (.clock(clock), .sys_rst(sys_rst),
			.push(push[i]), .pop(pop[i]), .flags(qf[i]));
	end
	afei_fifo_event_irq afei_fifo_event_irq_inst (.clock(clock), .sys_rst(sys_rst),
		.ch0_result_queue(qf[0]), .ch1_result_queue(qf[1]), .ch2_result_queue(qf[2]),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_byteenable(4'hf),
		.avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.avs_response(resp), .proc_irq(irq));
	////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Called just after a rising edge; holds the request until waitrequest is low
	task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0) errors++;
		rv = rdata;
		rr = resp;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clock);
	endtask : access
	task automatic expect_read(input logic [31:0] a, input logic [31:0] e);
		access(1'b0, a, 32'h0);
		check("readdata", rv, e);
		check("resp", {30'h0, rr}, 32'h0);
	endtask : expect_read
	task automatic feed(input int c, input int n);
		repeat (n) begin
			push[c] <= 1'b1;
			@(posedge clock);
		end
		push <= 3'h0;
		repeat (3) @(posedge clock);
	endtask : feed
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		{sys_rst, rd, wr, addr, wdata, push, pop} = {3'h4, 64'h0, 6'h0};
		{errors, compares, cycles, st, en} = '0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		expect_read(ENABLE_ADDR, 32'h0);
		expect_read(STATUS_ADDR, 32'h0);
		check("irq", {23'h0, irq}, 32'h0);
		access(1'b1, ENABLE_ADDR, 32'hffff_ffff);
		en = 9'h1ff;
		expect_read(ENABLE_ADDR, 32'h1ff);
		expect_read(CLEAR_ADDR, 32'h0);
		access(1'b1, STATUS_ADDR, 32'hffff_ffff);
		check("resp", {30'h0, rr}, 32'h2);
		access(1'b0, 32'h4002_1224, 32'h0);
		check("resp", {30'h0, rr}, 32'h2);
		expect_read(STATUS_ADDR, 32'h0);
		for (int c = 0; c < 3; c++) begin
			feed(c, 1);
			st[3*c+2] = 1'b1;
			expect_read(STATUS_ADDR, {23'h0, st});
			feed(c, 2);
			st[3*c+1] = 1'b1;
			expect_read(STATUS_ADDR, {23'h0, st});
			feed(c, 1);
			st[3*c] = 1'b1;
			expect_read(STATUS_ADDR, {23'h0, st});
			check("irq", {23'h0, irq}, {23'h0, st & en});
		end
		expect_read(STATUS_ADDR, 32'h1ff);
		pop <= 3'h7;
		repeat (6) @(posedge clock);
		pop <= 3'h0;
		repeat (3) @(posedge clock);
		expect_read(STATUS_ADDR, 32'h1ff);
		access(1'b1, CLEAR_ADDR, 32'hffff_fef0);
		st = 9'h10f;
		expect_read(STATUS_ADDR, {23'h0, st});
		access(1'b1, ENABLE_ADDR, 32'h3);
		en = 9'h003;
		check("irq", {23'h0, irq}, {23'h0, st & en});
		// Channel 0 turns non-empty in the very cycle the clear is taken
		fork
			access(1'b1, CLEAR_ADDR, 32'h4);
			feed(0, 1);
		join
		expect_read(STATUS_ADDR, {23'h0, st});
		access(1'b1, CLEAR_ADDR, 32'h4);
		st = 9'h10b;
		expect_read(STATUS_ADDR, {23'h0, st});
		report_and_stop();
	end
endmodule : tb_afei_fifo_event_irq
